/* hdl/mdc_consts.vh */
// Purpose: shared constants of the multi-device serial chain block
// Assumes: 10 MHz system clock, 8 channels of 24-bit results
// Notes: command codes and config_reg_one layout are local choices
`ifndef MDC_CONSTS_VH
`define MDC_CONSTS_VH

`define MDC_CLK_MHZ 10
`define MDC_DR_PERIOD_US 4000
`define MDC_DR_PERIOD_CYC (`MDC_DR_PERIOD_US * `MDC_CLK_MHZ)

`define MDC_CH_COUNT 8
`define MDC_RES_BITS 24
`define MDC_STATUS_BITS 24
`define MDC_DATA_BITS (`MDC_CH_COUNT * `MDC_RES_BITS)
`define MDC_FRAME_BITS (`MDC_STATUS_BITS + `MDC_DATA_BITS)

`define MDC_ADDR_CFG_ONE 5'h01
`define MDC_ADDR_CFG_FOUR 5'h17
`define MDC_CFG_ONE_RESET 8'h00
`define MDC_CFG_FOUR_RESET 8'h00
`define MDC_CHAIN_EN_BIT 6
`define MDC_CLK_OUT_EN_BIT 5
`define MDC_SINGLE_SHOT_BIT 3
`define MDC_DETACH_CMP_BIT 1

`define MDC_CMD_WRITE 3'h2
`define MDC_CMD_READ 3'h1
`define MDC_CMD_START 8'h08
`define MDC_CMD_STOP 8'h0A

`define MDC_PIN_SCLK 0
`define MDC_PIN_CS_N 1
`define MDC_PIN_DIN 2
`define MDC_PIN_CHAIN 3
`define MDC_PIN_START 4
`define MDC_PIN_CLKSRC 5
`define MDC_PIN_COUNT 6

`endif

/* hdl/mdc_serial_chain.v */
// Purpose: serial output sharing, chaining, config_reg_four and start sync
// Assumes: host drives sclk, cs_n, din and start; analog core feeds samples
// Notes: all pins are sampled by the 10 MHz clock; sclk must stay well slower
//
// How it works
// R1: config_reg_four bit 3 selects single-shot conversions
// R2: config_reg_four bit 1 powers detach comparators
// R3: host writes zeros to reserved bits
// R4: chip select high floats the data output
// R5: cascade shares lines, one select per device
// R6: chaining only when config_reg_one chain bit set
// R7: chain: next device output feeds chain input
// R8: own status and data first, then next device
// R9: no repeated readback while chaining
// R10: output bit changes on serial clock rise
// R11: chain input sampled on serial clock fall
// R12: start to done delay fixed per rate
// R13: clock master drives clock out when enabled
// R14: shared data in needs identical settings
// R15: host may start by serial command instead
// R16: optional retiming flop on inverted serial clock
// R17: host unpacks bits straddling byte boundaries
// R18: host bounds chain length by frame timing
// R19: host reads detach state from status bits
// R20: after own frame, forward chain input bits
`timescale 1ns/1ns
`include "mdc_consts.vh"

module mdc_serial_chain #(
  parameter DR_PERIOD_CYC = `MDC_DR_PERIOD_CYC
)
(
  input wire clock,
  input wire rst_n,
  input wire sclk,
  input wire cs_n,
  input wire din,
  input wire chain_in,
  input wire start,
  input wire clock_source_pin,
  input wire [`MDC_FRAME_BITS-1:0] sample_data,
  input wire sample_valid,
  output reg sample_ready,
  output reg dout_o,
  output reg dout_oe,
  output reg conversion_done_n,
  output reg clk_out_o,
  output reg clk_out_oe,
  output reg single_shot_mode,
  output reg detach_comparator_on,
  output reg chain_mode
);

  localparam FB = `MDC_FRAME_BITS;
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_WDATA = 2'h1;
  localparam [1:0] ST_SKIP = 2'h2;
  localparam [31:0] PERIOD_FULL = DR_PERIOD_CYC - 1;
  localparam [16:0] PERIOD_LAST = PERIOD_FULL[16:0];

  wire [`MDC_PIN_COUNT-1:0] pin_raw;
  wire [`MDC_PIN_COUNT-1:0] pin_lvl;
  wire [`MDC_PIN_COUNT-1:0] pin_rise;
  wire [`MDC_PIN_COUNT-1:0] pin_fall;

  assign pin_raw = {clock_source_pin, start, chain_in, din, cs_n, sclk};

  // pins from the host are asynchronous; a change counts once two stages agree
  genvar gi;
  generate
    for (gi = 0; gi < `MDC_PIN_COUNT; gi = gi + 1)
    begin : g_pin
      // stages start at the idle level of the pin, so reset makes no false edge
      localparam [0:0] IDLE_LVL = (gi == `MDC_PIN_CS_N) ? 1'b1 : 1'b0;
      reg s1_ff;
      reg s2_ff;
      reg s3_ff;
      reg lvl_ff;
      always @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
        begin
          s1_ff <= IDLE_LVL;
          s2_ff <= IDLE_LVL;
          s3_ff <= IDLE_LVL;
          lvl_ff <= IDLE_LVL;
        end
        else
        begin
          s1_ff <= pin_raw[gi];
          s2_ff <= s1_ff;
          s3_ff <= s2_ff;
          if (s2_ff == s3_ff)
            lvl_ff <= s2_ff;
        end
      end
      assign pin_lvl[gi] = lvl_ff;
      assign pin_rise[gi] = (s2_ff == s3_ff) && s2_ff && !lvl_ff;
      assign pin_fall[gi] = (s2_ff == s3_ff) && !s2_ff && lvl_ff;
    end
  endgenerate

  wire sel = !pin_lvl[`MDC_PIN_CS_N];
  wire sclk_rise = pin_rise[`MDC_PIN_SCLK] && sel;
  wire sclk_fall = pin_fall[`MDC_PIN_SCLK] && sel;

  // configuration registers
  reg [7:0] cfg_one_ff;
  reg [7:0] cfg_four_ff;
  wire chain_en = cfg_one_ff[`MDC_CHAIN_EN_BIT];

  // command decoder, bytes on din sampled on sclk falls
  reg [1:0] cmd_state_ff;
  reg [2:0] bit_cnt_ff;
  reg [6:0] cmd_sr_ff;
  reg [4:0] cmd_addr_ff;
  reg chain_bit_ff;
  wire [7:0] rx_byte = {cmd_sr_ff, pin_lvl[`MDC_PIN_DIN]};
  wire byte_done = sclk_fall && (bit_cnt_ff == 3'h7);
  wire is_write = byte_done && (cmd_state_ff == ST_IDLE) && (rx_byte[7:5] == `MDC_CMD_WRITE);
  wire is_read = byte_done && (cmd_state_ff == ST_IDLE) && (rx_byte[7:5] == `MDC_CMD_READ);
  wire start_cmd = byte_done && (cmd_state_ff == ST_IDLE) && (rx_byte == `MDC_CMD_START);
  wire stop_cmd = byte_done && (cmd_state_ff == ST_IDLE) && (rx_byte == `MDC_CMD_STOP);
  wire wr_data = byte_done && (cmd_state_ff == ST_WDATA);

  reg [7:0] rd_value;
  always @*
  begin
    case (rx_byte[4:0])
      `MDC_ADDR_CFG_ONE: rd_value = cfg_one_ff;
      `MDC_ADDR_CFG_FOUR: rd_value = cfg_four_ff;
      default: rd_value = 8'h00;
    endcase
  end

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_state_ff <= ST_IDLE;
      bit_cnt_ff <= 3'h0;
      cmd_sr_ff <= 7'h00;
      cmd_addr_ff <= 5'h00;
      chain_bit_ff <= 1'b0;
    end
    else if (!sel)
    begin
      cmd_state_ff <= ST_IDLE;
      bit_cnt_ff <= 3'h0;
    end
    else if (sclk_fall)
    begin
      chain_bit_ff <= pin_lvl[`MDC_PIN_CHAIN]; // R11
      cmd_sr_ff <= rx_byte[6:0];
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
      if (byte_done)
      begin
        case (cmd_state_ff)
          ST_IDLE:
          begin
            if (is_write)
            begin
              cmd_addr_ff <= rx_byte[4:0];
              cmd_state_ff <= ST_WDATA;
            end
            else if (is_read)
              cmd_state_ff <= ST_SKIP;
          end
          ST_WDATA: cmd_state_ff <= ST_IDLE;
          ST_SKIP: cmd_state_ff <= ST_IDLE;
          default: cmd_state_ff <= ST_IDLE;
        endcase
      end
    end
  end

  // reserved bits are stored as written; software is expected to keep them 0
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_one_ff <= `MDC_CFG_ONE_RESET;
      cfg_four_ff <= `MDC_CFG_FOUR_RESET;
    end
    else if (wr_data)
    begin
      if (cmd_addr_ff == `MDC_ADDR_CFG_ONE)
        cfg_one_ff <= rx_byte; // R6
      if (cmd_addr_ff == `MDC_ADDR_CFG_FOUR)
        cfg_four_ff <= rx_byte; // R3
    end
  end

  // two-entry sample buffer between the converter core and the shifter
  reg [FB-1:0] buf0_ff;
  reg [FB-1:0] buf1_ff;
  reg [1:0] buf_cnt_ff;
  reg [1:0] nxt_buf_cnt;
  wire push = sample_valid && sample_ready;
  wire pop;

  always @*
  begin
    nxt_buf_cnt = buf_cnt_ff;
    if (push && !pop)
      nxt_buf_cnt = buf_cnt_ff + 2'h1;
    else if (pop && !push)
      nxt_buf_cnt = buf_cnt_ff - 2'h1;
  end

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      buf0_ff <= {FB{1'b0}};
      buf1_ff <= {FB{1'b0}};
      buf_cnt_ff <= 2'h0;
      sample_ready <= 1'b0;
    end
    else
    begin
      buf_cnt_ff <= nxt_buf_cnt;
      sample_ready <= (nxt_buf_cnt != 2'h2);
      if (pop)
        buf0_ff <= (push && buf_cnt_ff == 2'h1) ? sample_data : buf1_ff;
      else if (push && buf_cnt_ff == 2'h0)
        buf0_ff <= sample_data;
      if (push && (buf_cnt_ff == 2'h2 || (buf_cnt_ff == 2'h1 && !pop)))
        buf1_ff <= sample_data;
    end
  end

  // conversion pacing: a fixed period from start to each data-ready
  reg running_ff;
  reg [16:0] period_cnt_ff;
  wire start_go = pin_rise[`MDC_PIN_START] || start_cmd;
  wire period_end = running_ff && (period_cnt_ff == 17'h0);
  assign pop = period_end && (buf_cnt_ff != 2'h0);

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      running_ff <= 1'b0;
      period_cnt_ff <= 17'h0;
    end
    else if (start_go)
    begin
      running_ff <= 1'b1; // R12
      period_cnt_ff <= PERIOD_LAST;
    end
    else if (pin_fall[`MDC_PIN_START] || stop_cmd)
      running_ff <= 1'b0;
    else if (period_end)
    begin
      period_cnt_ff <= PERIOD_LAST;
      if (cfg_four_ff[`MDC_SINGLE_SHOT_BIT])
        running_ff <= 1'b0; // R1
    end
    else if (running_ff)
      period_cnt_ff <= period_cnt_ff - 17'h1;
  end

  // output shifter: chained mode fills from the chain input, else it rotates
  reg [FB-1:0] out_sr_ff;
  wire fill_bit = chain_en ? chain_bit_ff : out_sr_ff[FB-1]; // R9

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_sr_ff <= {FB{1'b0}};
      dout_o <= 1'b0;
    end
    else
    begin
      if (is_read)
        out_sr_ff <= {rd_value, {(FB - 8){1'b0}}};
      else if (pop)
        out_sr_ff <= buf0_ff; // R8
      else if (sclk_rise)
        out_sr_ff <= {out_sr_ff[FB-2:0], fill_bit}; // R20
      else if (sclk_fall && chain_en)
        out_sr_ff[0] <= pin_lvl[`MDC_PIN_CHAIN]; // R11
      if (sclk_rise)
        dout_o <= out_sr_ff[FB-1]; // R10
    end
  end

  // done goes low at each new frame and high once the host starts clocking
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      conversion_done_n <= 1'b1;
    else if (pop)
      conversion_done_n <= 1'b0; // R12
    else if (sclk_rise)
      conversion_done_n <= 1'b1;
  end

  // clock out toggles each cycle; gated by the next enable so it is never left high
  wire nxt_clk_out_oe = pin_lvl[`MDC_PIN_CLKSRC] && cfg_one_ff[`MDC_CLK_OUT_EN_BIT];
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clk_out_o <= 1'b0;
      clk_out_oe <= 1'b0;
    end
    else
    begin
      clk_out_oe <= nxt_clk_out_oe; // R13
      clk_out_o <= nxt_clk_out_oe ? !clk_out_o : 1'b0;
    end
  end

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dout_oe <= 1'b0;
      single_shot_mode <= 1'b0;
      detach_comparator_on <= 1'b0;
      chain_mode <= 1'b0;
    end
    else
    begin
      dout_oe <= sel; // R4
      single_shot_mode <= cfg_four_ff[`MDC_SINGLE_SHOT_BIT]; // R1
      detach_comparator_on <= cfg_four_ff[`MDC_DETACH_CMP_BIT]; // R2
      chain_mode <= chain_en; // R6
    end
  end

endmodule

/* verification/mdc_chain_assertions.sv */
// Purpose: pin level checks of the serial chain block
// Assumes: sclk phases of at least 4 clocks
// Notes: lags allow for the pin synchronisers
`timescale 1ns/1ns
module mdc_chain_assertions (
  input wire clock,
  input wire rst_n,
  input wire sclk,
  input wire cs_n,
  input wire start,
  input wire clock_source_pin,
  input wire dout_o,
  input wire dout_oe,
  input wire conversion_done_n,
  input wire clk_out_o,
  input wire clk_out_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_cs_float: assert property (cs_n [*6] |-> !dout_oe) else $error("dout driven");
  a_cs_drive: assert property (!cs_n [*6] |-> dout_oe) else $error("dout floats");
  a_oe_fall: assert property ($fell(dout_oe) |-> $past(cs_n, 4)) else $error("oe drop");
  a_oe_rise: assert property ($rose(dout_oe) |-> !$past(cs_n, 4)) else $error("oe rise");
  a_dout_rise: assert property (dout_oe && $past(dout_oe) && $changed(dout_o)
    |-> $past(sclk, 3) && $past(sclk, 4)) else $error("dout moved off sclk rise");
  a_done_start: assert property ($fell(conversion_done_n) |-> $past(start, 8) || !$past(cs_n, 8))
    else $error("done without start");
  a_clk_gate: assert property (!clk_out_oe |-> !clk_out_o) else $error("clock out idle");
  a_clk_toggle: assert property (clk_out_oe && $past(clk_out_oe)
    |-> clk_out_o != $past(clk_out_o)) else $error("clock out stuck");
  a_clk_strap: assert property (!clock_source_pin [*6] |-> !clk_out_oe)
    else $error("clock out without strap");
endmodule
bind mdc_serial_chain mdc_chain_assertions u_chk (.clock(clock), .rst_n(rst_n), .sclk(sclk),
  .cs_n(cs_n), .start(start), .clock_source_pin(clock_source_pin), .dout_o(dout_o),
  .dout_oe(dout_oe), .conversion_done_n(conversion_done_n), .clk_out_o(clk_out_o),
  .clk_out_oe(clk_out_oe));

/* verification/mdc_host_model.sv */
// Purpose: host serial port plus the next device down the chain
// Assumes: 800 ns sclk, phases of 4 clocks, driven at clock fall
// Notes: neighbour output moves on sclk rise like a real device
`timescale 1ns/1ns
module mdc_host_model (
  input wire clock,
  input wire dout_o,
  output reg sclk = 1'h0,
  output reg cs_n = 1'h1,
  output reg din = 1'h0,
  output reg chain_in = 1'h0
);
  reg [215:0] nb_ff = 216'h0;
  task wt(input integer n);
    repeat (n) @(negedge clock);
  endtask
  // one select framed transfer, msb first, sampled mid low phase
  task shift(input [231:0] tx, output [231:0] rx);
    integer i;
    begin
      cs_n = 1'h0;
      wt(6);
      for (i = 231; i >= 0; i = i - 1)
      begin
        din = tx[i];
        // neighbour wired straight; no retiming flop needed at this sclk rate
        chain_in = nb_ff[215];
        nb_ff = {nb_ff[214:0], ~nb_ff[215]};
        sclk = 1'h1;
        wt(4);
        sclk = 1'h0;
        wt(2);
        rx[i] = dout_o;
        wt(2);
      end
      cs_n = 1'h1;
      chain_in = ~chain_in;
      wt(8);
    end
  endtask
endmodule

/* verification/tb_top.sv */
// Purpose: bench for the serial chain block
// Assumes: conversion period cut to 20 clocks
// Notes: frames shift out right after done, no command byte
`timescale 1ns/1ns
`include "mdc_consts.vh"
module tb_top;
  reg clock = 1'h0;
  reg rst_n = 1'h0;
  reg start = 1'h0;
  reg clock_source_pin = 1'h0;
  reg [215:0] frame = {9{24'hC3A51E}};
  reg [231:0] rx;
  wire sclk, cs_n, din, chain_in, ready, dout_o, dout_oe, done_n, ck_o, ck_oe, ss, det, chn;
  integer mismatches = 0;
  integer samples_checked = 0;
  integer i;
  integer done_falls = 0;
  integer falls_seen = 0;
  always @(negedge done_n) done_falls = done_falls + 1;
  initial forever #50 clock = ~clock;
  mdc_host_model host (.clock(clock), .dout_o(dout_o), .sclk(sclk), .cs_n(cs_n), .din(din),
    .chain_in(chain_in));
  mdc_serial_chain #(.DR_PERIOD_CYC(20)) DUT (.clock(clock), .rst_n(rst_n), .sclk(sclk),
    .cs_n(cs_n), .din(din), .chain_in(chain_in), .start(start),
    .clock_source_pin(clock_source_pin), .sample_data(frame), .sample_valid(1'h1),
    .sample_ready(ready), .dout_o(dout_o), .dout_oe(dout_oe), .conversion_done_n(done_n),
    .clk_out_o(ck_o), .clk_out_oe(ck_oe), .single_shot_mode(ss),
    .detach_comparator_on(det), .chain_mode(chn));
  task check(input [231:0] seen, input [231:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp)
      begin
        mismatches = mismatches + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [4:0] a, input [7:0] d);
    host.shift({`MDC_CMD_WRITE, a, d, 216'h0}, rx);
  endtask
  task rd(input [4:0] a, input [7:0] exp);
    begin
      host.shift({`MDC_CMD_READ, a, 224'h0}, rx);
      check(rx[223:216], exp);
    end
  endtask
  // bounded wait, caller judges the level
  task wait_done;
    for (i = 0; i < 60 && done_n !== 1'h0; i = i + 1)
      @(negedge clock);
  endtask
  task print_verdict;
    begin
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  initial
  begin
    repeat (20) @(negedge clock);
    rst_n = 1'h1;
    repeat (8) @(negedge clock);
    check(ready, 1'h0);
    rd(`MDC_ADDR_CFG_FOUR, 8'h00);
    rd(5'h05, 8'h00);
    wr(`MDC_ADDR_CFG_FOUR, 8'h0A);
    rd(`MDC_ADDR_CFG_FOUR, 8'h0A);
    check({ss, det, dout_oe}, 3'h6);
    $display("test registers ended");
    start = 1'h1;
    wait_done;
    check(done_n, 1'h0);
    host.nb_ff = ~frame;
    host.shift(232'h0, rx);
    check(rx, {frame, frame[215:200]});
    wait_done;
    check(done_n, 1'h1);
    $display("test single shot ended");
    start = 1'h0;
    wr(`MDC_ADDR_CFG_ONE, 8'h40);
    check(chn, 1'h1);
    start = 1'h1;
    wait_done;
    host.nb_ff = ~frame;
    host.shift(232'h0, rx);
    check(rx, {frame, ~frame[215:200]});
    check(rx[231:208], frame[215:192]);
    $display("test chain ended");
    start = 1'h0;
    wr(`MDC_ADDR_CFG_FOUR, 8'h02);
    check({ss, det}, 2'h1);
    start = 1'h1;
    wait_done;
    host.shift(232'h0, rx);
    wait_done;
    check(done_n, 1'h0);
    start = 1'h0;
    $display("test continuous ended");
    wr(`MDC_ADDR_CFG_FOUR, 8'h08);
    falls_seen = done_falls;
    host.shift({`MDC_CMD_START, 224'h0}, rx);
    check(done_falls - falls_seen, 1);
    wr(`MDC_ADDR_CFG_FOUR, 8'h00);
    falls_seen = done_falls;
    host.shift({`MDC_CMD_START, 216'h0, `MDC_CMD_STOP}, rx);
    check(done_falls - falls_seen > 40, 1);
    falls_seen = done_falls;
    repeat (60) @(negedge clock);
    check(done_falls - falls_seen, 0);
    $display("test start command ended");
    clock_source_pin = 1'h1;
    wr(`MDC_ADDR_CFG_ONE, 8'h20);
    check({ck_oe, chn}, 2'h2);
    clock_source_pin = 1'h0;
    repeat (8) @(negedge clock);
    check(ck_oe, 1'h0);
    $display("test clock out ended");
    print_verdict;
  end
  initial
  begin
    #4000000;
    mismatches = mismatches + 1;
    print_verdict;
  end
endmodule
